// ---- rtl/chg_pkg.sv ----
package chg_pkg;

    // clock and power-on-reset delay
    localparam int CLK_MHZ     = 50;
    localparam int POR_TIME_US = 1000;
    localparam int POR_CYCLES  = POR_TIME_US * CLK_MHZ;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control register fields
    localparam int         CTRL_W          = 3;
    localparam int         CTRL_CE_PRESENT = 0;
    localparam int         CTRL_TS_PRESENT = 1;
    localparam int         CTRL_INHIBIT    = 2;
    localparam logic [2:0] CTRL_RESET      = 3'h3;

    // status register fields
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_PASS      = 8;
    localparam int STAT_FAULT_I   = 9;
    localparam int STAT_DETECT_I  = 10;
    localparam int STAT_PIN_A     = 11;
    localparam int STAT_PIN_B     = 12;
    localparam int STAT_PIN_GOOD  = 13;
    localparam int STAT_SENSE_LSB = 16;

    // sensed input vector layout
    localparam int SENSE_W    = 11;
    localparam int S_IN_DET   = 0;
    localparam int S_OVP      = 1;
    localparam int S_TEMP_OK  = 2;
    localparam int S_JUNCTION_SHUTDOWN_LIMIT    = 3;
    localparam int S_TFAULT   = 4;
    localparam int S_TERM     = 5;
    localparam int S_SHORT    = 6;
    localparam int S_CE_N     = 7;
    localparam int S_TMR_OPEN = 8;
    localparam int S_BAT_LOW  = 9;
    localparam int S_ABSENT   = 10;
    localparam logic [10:0] SENSE_RESET = 11'h080;

    typedef enum logic [5:0] {
        ST_SLEEP    = 6'h01,
        ST_POR      = 6'h02,
        ST_STANDBY  = 6'h04,
        ST_BEGIN    = 6'h08,
        ST_CHARGING = 6'h10,
        ST_SUSPEND  = 6'h20
    } mode_e;

endpackage

// ---- rtl/sense_capture.sv ----
`timescale 1ns/1ps
module sense_capture #(
    parameter int               W         = chg_pkg::SENSE_W,
    parameter logic [W-1:0]     RESET_VAL = chg_pkg::SENSE_RESET
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] sensed
);

    // comparator and latch results taken on the clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sensed <= RESET_VAL;
        end else begin
            sensed <= raw;
        end
    end

endmodule

// ---- rtl/por_delay_timer.sv ----
`timescale 1ns/1ps
module por_delay_timer #(
    parameter int CYCLES = chg_pkg::POR_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      done
);

    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] count_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= W'(CYCLES);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    // done rises as the count runs out and stays until the next start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else if (start) begin
            done <= 1'b0;
        end else if (count_reg == W'(1)) begin
            done <= 1'b1;
        end
    end

endmodule

// ---- rtl/charger_mode_control_fsm.sv ----
`timescale 1ns/1ps
// Function
// - Below power-down threshold everything is off, pins ignored, outputs high impedance.
// - Sleep: charger off, pins ignored, status outputs released, power-good shows no input.
// - Loss of input-detected forces sleep from any state.
// - Input detected in sleep enters power-on-reset, starting delay and resetting blocks.
// - During power-on-reset delay status shows charger off, power-good shows no input.
// - After the delay comparators enable and outputs drive real values.
// - Delay end with enable pin high enters stand-by; timers reset, pins watched.
// - Without an enable pin, delay end goes straight to begin-charge.
// - Begin-charge resets all timers once conditions hold, then goes charging.
// - Temperature out of range suspends with timers frozen; resumes when back.
// - Open timer pin: regulator mode, no termination, no detect, timer clock reset.
// - Enable low starts a new charge cycle; enable high disables charging.
// - Without temperature input, pack temperature counts as always in range.
// - Pass switch on only with enable, input, no latched flags, temp ok, cool junction.
// - Enable, input and timer fault: main path off, only fault-recovery current.
// - Enable, input but pack hot or cold: output stage off.
// - Timer-fault, termination and short flags are latched outside; only read here.
// - Status pair: precharge on/on, fast on/off, done off/on, else off/off.
// - Power-good low only with input and no overvoltage, else high impedance.
// - Overvoltage turns charger off into stand-by, unlatched, recovers when cleared.
module charger_mode_control_fsm #(
    parameter int POR_CYCLES = chg_pkg::POR_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        input_detected,
    input  wire logic        input_overvoltage,
    input  wire logic        pack_temp_sense,
    input  wire logic        junction_shutdown_limit,
    input  wire logic        timer_fault_latched,
    input  wire logic        termination_latched,
    input  wire logic        output_short_latched,
    input  wire logic        charge_enable_n,
    input  wire logic        timer_program_pin,
    input  wire logic        battery_low,
    input  wire logic        battery_absent,
    input  wire logic        status_out_a_i,
    output logic             status_out_a_o,
    output logic             status_out_a_oe,
    input  wire logic        status_out_b_i,
    output logic             status_out_b_o,
    output logic             status_out_b_oe,
    input  wire logic        input_good_n_i,
    output logic             input_good_n_o,
    output logic             input_good_n_oe,
    output logic             pass_switch_en,
    output logic             fault_recovery_current,
    output logic             battery_detect_current,
    output logic             comparators_en,
    output logic             blocks_reset,
    output logic             safety_timer_reset,
    output logic             safety_timer_hold,
    output logic             termination_en,
    output logic             battery_detect_en
);

    logic [chg_pkg::SENSE_W-1:0] sense_raw;
    logic [chg_pkg::SENSE_W-1:0] sense_reg;
    logic [chg_pkg::CTRL_W-1:0]  ctrl_reg;
    chg_pkg::mode_e              state_reg;
    chg_pkg::mode_e              state_next;
    logic                        por_start;
    logic                        por_done;
    logic                        in_det;
    logic                        ovp;
    logic                        temp_ok;
    logic                        ce_n;
    logic                        tmr_open;
    logic                        flags_clear;
    logic                        pass_next;
    logic                        fault_i_next;
    logic                        detect_i_next;
    logic                        stat_a_next;
    logic                        stat_b_next;
    logic                        wr_pend_reg;
    logic [7:0]                  wr_addr_reg;
    logic                        addr_phase;

    function automatic logic hits(input logic [31:0] addr, input logic [7:0] offset);
        hits = (addr[31:8] == 24'h000000) && (addr[7:0] == offset);
    endfunction

    assign sense_raw = {battery_absent, battery_low, timer_program_pin, charge_enable_n,
                        output_short_latched, termination_latched, timer_fault_latched,
                        junction_shutdown_limit, pack_temp_sense, input_overvoltage,
                        input_detected};

    // inputs registered before the machine sees them
    sense_capture #(
        .W         (chg_pkg::SENSE_W),
        .RESET_VAL (chg_pkg::SENSE_RESET)
    ) u_sense (
        .mclk   (mclk),
        .rstn   (rstn),
        .raw    (sense_raw),
        .sensed (sense_reg)
    );

    assign in_det   = sense_reg[chg_pkg::S_IN_DET];
    assign ovp      = sense_reg[chg_pkg::S_OVP];
    assign tmr_open = sense_reg[chg_pkg::S_TMR_OPEN];
    assign temp_ok  = !ctrl_reg[chg_pkg::CTRL_TS_PRESENT]
                      || sense_reg[chg_pkg::S_TEMP_OK];
    assign ce_n     = (ctrl_reg[chg_pkg::CTRL_CE_PRESENT] && sense_reg[chg_pkg::S_CE_N])
                      || ctrl_reg[chg_pkg::CTRL_INHIBIT];
    assign flags_clear = !sense_reg[chg_pkg::S_TFAULT] && !sense_reg[chg_pkg::S_TERM]
                         && !sense_reg[chg_pkg::S_SHORT];

    assign por_start = (state_reg == chg_pkg::ST_SLEEP) && in_det;

    por_delay_timer #(
        .CYCLES (POR_CYCLES)
    ) u_por (
        .mclk  (mclk),
        .rstn  (rstn),
        .start (por_start),
        .done  (por_done)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            chg_pkg::ST_SLEEP: begin
                if (in_det) state_next = chg_pkg::ST_POR;
            end
            chg_pkg::ST_POR: begin
                if (por_done) begin
                    if (ce_n || ovp) state_next = chg_pkg::ST_STANDBY;
                    else state_next = chg_pkg::ST_BEGIN;
                end
            end
            chg_pkg::ST_STANDBY: begin
                if (!ce_n && !ovp) state_next = chg_pkg::ST_BEGIN;
            end
            chg_pkg::ST_BEGIN: begin
                if (ce_n || ovp) state_next = chg_pkg::ST_STANDBY;
                else state_next = chg_pkg::ST_CHARGING;
            end
            chg_pkg::ST_CHARGING: begin
                if (ce_n || ovp) state_next = chg_pkg::ST_STANDBY;
                else if (!temp_ok) state_next = chg_pkg::ST_SUSPEND;
            end
            chg_pkg::ST_SUSPEND: begin
                if (ce_n || ovp) state_next = chg_pkg::ST_STANDBY;
                else if (temp_ok) state_next = chg_pkg::ST_CHARGING;
            end
        endcase
        if (!in_det) state_next = chg_pkg::ST_SLEEP;
    end

    // power-down is the asynchronous reset; it leaves the machine asleep
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= chg_pkg::ST_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        pass_next     = (state_reg == chg_pkg::ST_CHARGING) && !ce_n && in_det && !ovp
                        && flags_clear && temp_ok
                        && !sense_reg[chg_pkg::S_JUNCTION_SHUTDOWN_LIMIT];
        fault_i_next  = (state_reg == chg_pkg::ST_CHARGING || state_reg == chg_pkg::ST_SUSPEND)
                        && !ce_n && in_det && !ovp && sense_reg[chg_pkg::S_TFAULT];
        detect_i_next = (state_reg == chg_pkg::ST_CHARGING) && !ce_n && in_det && !ovp
                        && !tmr_open && !sense_reg[chg_pkg::S_TFAULT]
                        && !sense_reg[chg_pkg::S_TERM] && sense_reg[chg_pkg::S_SHORT]
                        && sense_reg[chg_pkg::S_ABSENT] && temp_ok
                        && !sense_reg[chg_pkg::S_JUNCTION_SHUTDOWN_LIMIT];
        stat_a_next   = pass_next;
        stat_b_next   = (pass_next && sense_reg[chg_pkg::S_BAT_LOW])
                        || ((state_reg == chg_pkg::ST_CHARGING) && !ce_n && !ovp && temp_ok
                            && !tmr_open && sense_reg[chg_pkg::S_TERM]
                            && !sense_reg[chg_pkg::S_TFAULT]
                            && !sense_reg[chg_pkg::S_SHORT]);
        if (state_reg == chg_pkg::ST_SUSPEND || state_reg == chg_pkg::ST_STANDBY) begin
            stat_b_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pass_switch_en         <= 1'b0;
            fault_recovery_current <= 1'b0;
            battery_detect_current <= 1'b0;
        end else begin
            pass_switch_en         <= pass_next;
            fault_recovery_current <= fault_i_next;
            battery_detect_current <= detect_i_next;
        end
    end

    // open-collector pins: oe high pulls the pin low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_out_a_o  <= 1'b0;
            status_out_a_oe <= 1'b0;
            status_out_b_o  <= 1'b0;
            status_out_b_oe <= 1'b0;
            input_good_n_o  <= 1'b0;
            input_good_n_oe <= 1'b0;
        end else begin
            status_out_a_o  <= 1'b0;
            status_out_a_oe <= stat_a_next;
            status_out_b_o  <= 1'b0;
            status_out_b_oe <= stat_b_next;
            input_good_n_o  <= 1'b0;
            input_good_n_oe <= in_det && !ovp && (state_reg != chg_pkg::ST_SLEEP)
                               && (state_reg != chg_pkg::ST_POR);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            comparators_en     <= 1'b0;
            blocks_reset       <= 1'b1;
            safety_timer_reset <= 1'b1;
            safety_timer_hold  <= 1'b0;
            termination_en     <= 1'b0;
            battery_detect_en  <= 1'b0;
        end else begin
            comparators_en     <= (state_reg != chg_pkg::ST_SLEEP)
                                  && (state_reg != chg_pkg::ST_POR);
            blocks_reset       <= (state_reg == chg_pkg::ST_SLEEP)
                                  || (state_reg == chg_pkg::ST_POR);
            safety_timer_reset <= tmr_open || (state_reg == chg_pkg::ST_STANDBY)
                                  || (state_reg == chg_pkg::ST_BEGIN)
                                  || (state_reg == chg_pkg::ST_SLEEP)
                                  || (state_reg == chg_pkg::ST_POR);
            safety_timer_hold  <= (state_reg == chg_pkg::ST_SUSPEND);
            termination_en     <= !tmr_open;
            battery_detect_en  <= !tmr_open;
        end
    end

    // bus slave: zero wait states, read data loaded at the address phase
    assign addr_phase = hsel && htrans[1] && hready;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
                if (hwrite || haddr[31:8] != 24'h000000) begin
                    hrdata <= 32'h00000000;
                end else if (hits(haddr, chg_pkg::CTRL_OFFSET)) begin
                    hrdata <= {29'h00000000, ctrl_reg};
                end else if (hits(haddr, chg_pkg::STATUS_OFFSET)) begin
                    hrdata <= {5'h00, sense_reg, 2'h0, input_good_n_i, status_out_b_i,
                               status_out_a_i, battery_detect_current,
                               fault_recovery_current, pass_switch_en, 2'h0, state_reg};
                end else begin
                    hrdata <= 32'h00000000;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= chg_pkg::CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == chg_pkg::CTRL_OFFSET) begin
            ctrl_reg <= hwdata[chg_pkg::CTRL_W-1:0];
        end
    end

    property p_sleep_on_loss;
        @(posedge mclk) disable iff (!rstn)
        !in_det |=> state_reg == chg_pkg::ST_SLEEP;
    endproperty
    a_sleep_on_loss: assert property (p_sleep_on_loss)
        else $error("no sleep on input loss");

    property p_por_entry;
        @(posedge mclk) disable iff (!rstn)
        (state_reg == chg_pkg::ST_SLEEP) && in_det |=> state_reg == chg_pkg::ST_POR;
    endproperty
    a_por_entry: assert property (p_por_entry) else $error("sleep did not enter por");

    property p_por_quiet;
        @(posedge mclk) disable iff (!rstn)
        state_reg == chg_pkg::ST_POR |=> !status_out_a_oe && !status_out_b_oe && !input_good_n_oe;
    endproperty
    a_por_quiet: assert property (p_por_quiet) else $error("outputs active during por");

    property p_switch_gate;
        @(posedge mclk) disable iff (!rstn)
        pass_switch_en |-> $past(in_det && !ce_n && flags_clear && temp_ok
                                 && !sense_reg[chg_pkg::S_JUNCTION_SHUTDOWN_LIMIT]);
    endproperty
    a_switch_gate: assert property (p_switch_gate)
        else $error("pass switch on illegally");

    property p_fault_current;
        @(posedge mclk) disable iff (!rstn)
        fault_recovery_current |-> !pass_switch_en ##1 1'b1;
    endproperty
    a_fault_current: assert property (p_fault_current)
        else $error("fault path with switch");

    property p_suspend;
        @(posedge mclk) disable iff (!rstn)
        (state_reg == chg_pkg::ST_CHARGING) && in_det && !ce_n && !ovp && !temp_ok
        |=> (state_reg == chg_pkg::ST_SUSPEND) ##1 safety_timer_hold && !pass_switch_en;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not entered");

    property p_regulator;
        @(posedge mclk) disable iff (!rstn)
        tmr_open |=> !termination_en && !battery_detect_en && safety_timer_reset;
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator mode not applied");

    property p_power_good;
        @(posedge mclk) disable iff (!rstn)
        input_good_n_oe |-> $past(in_det) && !$past(ovp);
    endproperty
    a_power_good: assert property (p_power_good) else $error("power good without input");

    property p_ovp_standby;
        @(posedge mclk) disable iff (!rstn)
        in_det && ovp && (state_reg == chg_pkg::ST_CHARGING)
        |=> state_reg == chg_pkg::ST_STANDBY;
    endproperty
    a_ovp_standby: assert property (p_ovp_standby) else $error("overvoltage ignored");

    property p_begin;
        @(posedge mclk) disable iff (!rstn)
        (state_reg == chg_pkg::ST_BEGIN) && in_det && !ce_n && !ovp
        |=> safety_timer_reset && state_reg == chg_pkg::ST_CHARGING;
    endproperty
    a_begin: assert property (p_begin) else $error("begin charge did not proceed");

endmodule

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    input  wire logic mclk,
    input  wire logic want_charge,
    input  wire logic oe_a,
    input  wire logic oe_b,
    input  wire logic oe_g,
    output logic      charge_enable_n,
    output logic      pin_a,
    output logic      pin_b,
    output logic      pin_g
);
    // low asks for charging, changed just after an edge
    always @(posedge mclk) charge_enable_n <= ~want_charge;
    // open-collector lines with pull-ups
    assign pin_a = oe_a ? 1'h0 : 1'h1;
    assign pin_b = oe_b ? 1'h0 : 1'h1;
    assign pin_g = oe_g ? 1'h0 : 1'h1;
endmodule

// ---- dv/charger_mode_control_fsm_tb_top.sv ----
`timescale 1ns/1ps
module charger_mode_control_fsm_tb_top;
    logic        mclk, rstn, hsel, hwrite, hreadyout, hresp, want_charge;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        input_detected, input_overvoltage, pack_temp_sense, junction_shutdown_limit;
    logic        timer_fault_latched, termination_latched, output_short_latched;
    logic        charge_enable_n, timer_program_pin, battery_low, battery_absent;
    logic        status_out_a_o, status_out_a_oe, status_out_b_o, status_out_b_oe;
    logic        input_good_n_o, input_good_n_oe, pin_a, pin_b, pin_g;
    logic        pass_switch_en, fault_recovery_current, battery_detect_current;
    logic        comparators_en, blocks_reset, safety_timer_reset, safety_timer_hold;
    logic        termination_en, battery_detect_en;
    int          bad_count, checks_done;

    charger_mode_control_fsm #(.POR_CYCLES(20)) uut (
        .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .input_detected, .input_overvoltage, .pack_temp_sense, .junction_shutdown_limit,
        .timer_fault_latched, .termination_latched, .output_short_latched,
        .charge_enable_n, .timer_program_pin, .battery_low, .battery_absent,
        .status_out_a_i(pin_a), .status_out_a_o, .status_out_a_oe,
        .status_out_b_i(pin_b), .status_out_b_o, .status_out_b_oe,
        .input_good_n_i(pin_g), .input_good_n_o, .input_good_n_oe,
        .pass_switch_en, .fault_recovery_current, .battery_detect_current,
        .comparators_en, .blocks_reset, .safety_timer_reset, .safety_timer_hold,
        .termination_en, .battery_detect_en
    );

    host_model host (
        .mclk, .want_charge, .oe_a(status_out_a_oe), .oe_b(status_out_b_oe),
        .oe_g(input_good_n_oe), .charge_enable_n, .pin_a, .pin_b, .pin_g
    );

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single AHB transfer, waits bounded on hready
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        int n;
        @(posedge mclk);
        hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
        n = 0;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'h1 && n < 20);
        htrans <= 2'h0; hsel <= 1'h0; hwdata <= d;
        do begin @(posedge mclk); n++; end while (hreadyout !== 1'h1 && n < 40);
        r = hrdata;
        if (n >= 40) begin
            bad_count++;
            close_out();
        end
    endtask

    // poll status until mode m, then read again and compare masked bits
    task automatic st(input chg_pkg::mode_e m, input logic [31:0] msk, exp);
        logic [31:0] r;
        int          n;
        n = 0;
        do begin ahb(1'h0, 32'h4, 32'h0, r); n++; end while (r[5:0] !== m && n < 60);
        if (n >= 60) begin
            bad_count++;
            $display("[ERR] %0t mode not reached", $time);
            close_out();
        end
        ahb(1'h0, 32'h4, 32'h0, r);
        chk(r & msk, exp | ({26'h0, m} & msk));
    endtask

    task automatic t_reset();
        logic [31:0] r;
        ahb(1'h0, 32'h0, 32'h0, r);
        chk(r, {29'h0, chg_pkg::CTRL_RESET});
        ahb(1'h0, 32'h8, 32'h0, r);
        chk(r, 32'h0);
        st(chg_pkg::ST_SLEEP, 32'h3F3F, 32'h3800);
        $display("t_reset done");
    endtask

    task automatic t_power_up();
        input_detected <= 1'h1;
        st(chg_pkg::ST_POR, 32'h3F3F, 32'h3800);
        st(chg_pkg::ST_STANDBY, 32'h3F3F, 32'h1800);
        chk({31'h0, comparators_en}, 32'h1);
        $display("t_power_up done");
    endtask

    task automatic t_charge();
        want_charge <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1100);
        battery_low <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h0100);
        battery_low <= 1'h0;
        termination_latched <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3900, 32'h0800);
        termination_latched <= 1'h0;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1100);
        $display("t_charge done");
    endtask

    task automatic t_suspend();
        pack_temp_sense <= 1'h0;
        st(chg_pkg::ST_SUSPEND, 32'h3F3F, 32'h1800);
        chk({31'h0, safety_timer_hold}, 32'h1);
        pack_temp_sense <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1100);
        $display("t_suspend done");
    endtask

    task automatic t_fault();
        timer_fault_latched <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3B3F, 32'h1A00);
        timer_fault_latched <= 1'h0;
        junction_shutdown_limit <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h013F, 32'h0000);
        junction_shutdown_limit <= 1'h0;
        st(chg_pkg::ST_CHARGING, 32'h013F, 32'h0100);
        output_short_latched <= 1'h1;
        battery_absent <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1C00);
        output_short_latched <= 1'h0;
        battery_absent <= 1'h0;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1100);
        $display("t_fault done");
    endtask

    task automatic t_ovp();
        input_overvoltage <= 1'h1;
        st(chg_pkg::ST_STANDBY, 32'h3F3F, 32'h3800);
        input_overvoltage <= 1'h0;
        st(chg_pkg::ST_CHARGING, 32'h3F3F, 32'h1100);
        $display("t_ovp done");
    endtask

    task automatic t_regulator();
        timer_program_pin <= 1'h1;
        repeat (6) @(posedge mclk);
        chk({29'h0, termination_en, battery_detect_en, safety_timer_reset}, 32'h1);
        timer_program_pin <= 1'h0;
        input_detected <= 1'h0;
        st(chg_pkg::ST_SLEEP, 32'h3F3F, 32'h3800);
        $display("t_regulator done");
    endtask

    task automatic t_variant();
        logic [31:0] r;
        ahb(1'h1, 32'h0, 32'h0, r);
        want_charge <= 1'h0;
        pack_temp_sense <= 1'h0;
        input_detected <= 1'h1;
        st(chg_pkg::ST_CHARGING, 32'h013F, 32'h0100);
        $display("t_variant done");
    endtask

    initial begin
        rstn = 1'h0; hsel = 1'h0; hwrite = 1'h0; haddr = 32'h0; hwdata = 32'h0;
        htrans = 2'h0; hsize = 3'h2; want_charge = 1'h0; input_detected = 1'h0;
        input_overvoltage = 1'h0; pack_temp_sense = 1'h1; junction_shutdown_limit = 1'h0;
        timer_fault_latched = 1'h0; termination_latched = 1'h0; output_short_latched = 1'h0;
        timer_program_pin = 1'h0; battery_low = 1'h0; battery_absent = 1'h0;
        bad_count = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        chk({28'h0, status_out_a_oe, status_out_b_oe, input_good_n_oe,
             pass_switch_en}, 32'h0);
        rstn <= 1'h1;
        t_reset();
        t_power_up();
        t_charge();
        t_suspend();
        t_fault();
        t_ovp();
        t_regulator();
        t_variant();
        close_out();
    end
endmodule
